// *** rtl/adc_selftrim_average_correction.sv ***
// Self-trim, continuous/averaged conversion control and result correction.
//
// Our own choice: strobed register access.
`include "adc_trim_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module adc_selftrim_average_correction #(
    parameter int TRIM_LEN = 64,
    parameter int CONV_LEN = 8
) (
    // Clock and reset
    input  wire logic                      clk_sys_i,
    input  wire logic                      srst_i,
    // Register port
    input  wire adc_trim_pkg::reg_req_t    req_i,
    output logic [31:0]                    rdata_o,
    // Converter side
    input  wire logic [15:0]               raw_sample_i,
    input  wire adc_trim_pkg::trim_words_t trim_found_i,
    input  wire logic                      stop_mode_i,
    input  wire adc_trim_pkg::res_mode_t   res_mode_i,
    // Status
    output logic                           conv_active_o,
    output logic                           result_done_o,
    output logic                           trimming_o
);
    import adc_trim_pkg::*;

    // =================================================================
    // Register decode
    logic        trim_start;
    logic        trim_fail;
    logic        cont_conv;
    logic        avg_en;
    logic [1:0]  avg_sel;
    logic [15:0] offset_corr;
    logic [15:0] plus_gain;
    trim_words_t trim;
    logic        hw_trig_sel;
    logic [15:0] result;
    logic        stop_s1;
    logic        stop_s2;

    wire wr_ctrl  = req_i.wr && req_i.addr == `OFS_TRIM_AVG_CTRL;
    wire wr_ofs   = req_i.wr && req_i.addr == `OFS_OFFSET_CORR;
    wire wr_gain  = req_i.wr && req_i.addr == `OFS_PLUS_GAIN;
    wire wr_trig  = req_i.wr && req_i.addr == `OFS_TRIG_CTRL;
    wire wr_d     = req_i.wr && req_i.addr == `OFS_TRIM_D;
    wire wr_s     = req_i.wr && req_i.addr == `OFS_TRIM_S;
    wire wr_4     = req_i.wr && req_i.addr == `OFS_TRIM_FOUR;
    wire wr_3     = req_i.wr && req_i.addr == `OFS_TRIM_THREE;
    wire wr_2     = req_i.wr && req_i.addr == `OFS_TRIM_TWO;
    wire wr_1     = req_i.wr && req_i.addr == `OFS_TRIM_ONE;
    wire wr_0     = req_i.wr && req_i.addr == `OFS_TRIM_ZERO;
    wire start_wr = wr_ctrl && req_i.wdata[`BIT_TRIM_START] && !trim_start;
    wire sw_trig  = wr_trig && req_i.wdata[`BIT_SW_TRIG];

    // =================================================================
    // Trim sequence
    logic [15:0] trim_cnt;
    logic        trim_bad;
    wire trim_last = trim_start && trim_cnt == 16'(TRIM_LEN - 1);
    wire fail_evt  = trim_start && (req_i.wr || hw_trig_sel || stop_s2);
    wire fail_now  = trim_bad || fail_evt;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            stop_s1 <= 1'b0;
            stop_s2 <= 1'b0;
        end else begin
            stop_s1 <= stop_mode_i;
            stop_s2 <= stop_s1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            trim_start <= 1'b0;
            trim_cnt   <= 16'h0000;
            trim_bad   <= 1'b0;
        end else if (start_wr) begin
            trim_start <= 1'b1;
            trim_cnt   <= 16'h0000;
            trim_bad   <= 1'b0;
        end else if (trim_last) begin
            trim_start <= 1'b0;
            trim_bad   <= 1'b0;
        end else if (trim_start) begin
            trim_cnt   <= trim_cnt + 16'h0001;
            trim_bad   <= fail_now;
        end
    end

    wire fail_clr = wr_ctrl && req_i.wdata[`BIT_TRIM_FAIL];
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            trim_fail <= 1'b0;
        end else if (trim_last) begin
            trim_fail <= fail_now;
        end else if (fail_clr) begin
            trim_fail <= 1'b0;
        end
    end

    // =================================================================
    // Control registers
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            cont_conv   <= 1'b0;
            avg_en      <= 1'b0;
            avg_sel     <= 2'h0;
            offset_corr <= `RST_OFFSET_CORR;
            plus_gain   <= `RST_PLUS_GAIN;
            hw_trig_sel <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                cont_conv <= req_i.wdata[`BIT_CONT];
                avg_en    <= req_i.wdata[`BIT_AVG_EN];
                avg_sel   <= req_i.wdata[1:0];
            end
            if (wr_ofs) offset_corr <= req_i.wdata[15:0];
            if (wr_gain) plus_gain <= req_i.wdata[15:0];
            if (wr_trig) hw_trig_sel <= req_i.wdata[`BIT_HW_TRIG];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            trim.d     <= `RST_TRIM_D;
            trim.s     <= `RST_TRIM_S;
            trim.four  <= `RST_TRIM_FOUR;
            trim.three <= `RST_TRIM_THREE;
            trim.two   <= `RST_TRIM_TWO;
            trim.one   <= `RST_TRIM_ONE;
            trim.zero  <= `RST_TRIM_ZERO;
        end else if (trim_last) begin
            trim <= trim_found_i;
        end else begin
            if (wr_d) trim.d <= req_i.wdata[5:0];
            if (wr_s) trim.s <= req_i.wdata[5:0];
            if (wr_4) trim.four <= req_i.wdata[9:0];
            if (wr_3) trim.three <= req_i.wdata[8:0];
            if (wr_2) trim.two <= req_i.wdata[7:0];
            if (wr_1) trim.one <= req_i.wdata[6:0];
            if (wr_0) trim.zero <= req_i.wdata[5:0];
        end
    end

    // =================================================================
    // Conversion sequencing
    logic [7:0]  conv_cnt;
    logic        conv_busy;
    logic [5:0]  avg_done;
    logic [20:0] acc;

    wire [5:0] set_size = 6'(6'd4 << avg_sel);
    wire [5:0] set_need = avg_en ? set_size : 6'd1;
    wire conv_end   = conv_busy && conv_cnt == 8'(CONV_LEN - 1);
    wire set_end    = conv_end && avg_done == 6'(set_need - 6'd1);

    wire signed [17:0] diff = $signed({2'b00, raw_sample_i})
                            - $signed({{2{offset_corr[15]}}, offset_corr});
    wire [15:0] max_val = (res_mode_i == RES_8BIT)  ? 16'h00FF :
                          (res_mode_i == RES_10BIT) ? 16'h03FF :
                          (res_mode_i == RES_12BIT) ? 16'h0FFF : 16'hFFFF;
    wire [15:0] corrected = diff < 0 ? 16'h0000 :
                            (diff > $signed({2'b00, max_val})) ? max_val :
                            diff[15:0];
    wire [20:0] acc_sum = acc + {5'h00, corrected};
    wire [20:0] mean = acc_sum >> ($clog2(32) - 3 + avg_sel + 2 - 2);
    wire [15:0] set_res = avg_en ? mean[15:0] : corrected;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            conv_busy     <= 1'b0;
            conv_cnt      <= 8'h00;
            avg_done      <= 6'h00;
            acc           <= 21'h000000;
            result        <= 16'h0000;
            result_done_o <= 1'b0;
        end else begin
            result_done_o <= 1'b0;
            if (start_wr || trim_start) begin
                conv_busy <= 1'b0;
                conv_cnt  <= 8'h00;
                avg_done  <= 6'h00;
                acc       <= 21'h000000;
            end else if (sw_trig && !conv_busy) begin
                conv_busy <= 1'b1;
                conv_cnt  <= 8'h00;
            end else if (conv_end) begin
                conv_cnt <= 8'h00;
                if (set_end) begin
                    result        <= set_res;
                    result_done_o <= 1'b1;
                    acc           <= 21'h000000;
                    avg_done      <= 6'h00;
                    conv_busy     <= cont_conv;
                end else begin
                    acc      <= acc_sum;
                    avg_done <= avg_done + 6'h01;
                end
            end else if (conv_busy) begin
                conv_cnt <= conv_cnt + 8'h01;
            end
        end
    end

    // =================================================================
    // Read data
    logic [31:0] rmux;
    always_comb begin
        rmux = 32'h0000_0000;
        unique case (req_i.addr)
            `OFS_TRIM_AVG_CTRL: rmux[7:0] = {trim_start, trim_fail, 2'b00,
                                  cont_conv, avg_en, avg_sel};
            `OFS_OFFSET_CORR: rmux[15:0] = offset_corr;
            `OFS_PLUS_GAIN:   rmux[15:0] = plus_gain;
            `OFS_TRIM_D:      rmux[5:0]  = trim.d;
            `OFS_TRIM_S:      rmux[5:0]  = trim.s;
            `OFS_TRIM_FOUR:   rmux[9:0]  = trim.four;
            `OFS_TRIM_THREE:  rmux[8:0]  = trim.three;
            `OFS_TRIM_TWO:    rmux[7:0]  = trim.two;
            `OFS_TRIM_ONE:    rmux[6:0]  = trim.one;
            `OFS_TRIM_ZERO:   rmux[5:0]  = trim.zero;
            `OFS_TRIG_CTRL:   rmux[0]    = hw_trig_sel;
            `OFS_RESULT:      rmux[15:0] = result;
            default:          rmux       = 32'h0000_0000;
        endcase
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            rdata_o       <= 32'h0000_0000;
            conv_active_o <= 1'b0;
            trimming_o    <= 1'b0;
        end else begin
            rdata_o       <= req_i.rd ? rmux : 32'h0000_0000;
            conv_active_o <= conv_busy;
            trimming_o    <= trim_start;
        end
    end

    // =================================================================
    // Assertions
    // self clear
    a_trim_ends_on_time: assert property (@(posedge clk_sys_i)
        disable iff (srst_i) $rose(trim_start) |-> ##64 !trim_start)
        else $error("trim did not end on time");
    a_write_fails_trim: assert property (@(posedge clk_sys_i)
        disable iff (srst_i) trim_start && req_i.wr && !trim_last
        |=> trim_bad || !trim_start)
        else $error("write during trim not marked");
    a_fail_holds: assert property (@(posedge clk_sys_i)
        disable iff (srst_i) trim_fail && !fail_clr && !trim_last
        |=> trim_fail)
        else $error("fail flag dropped");
    a_abort_conv: assert property (@(posedge clk_sys_i)
        disable iff (srst_i) start_wr |=> !conv_busy)
        else $error("conversion not aborted");
    a_result_bound: assert property (@(posedge clk_sys_i)
        disable iff (srst_i) result_done_o
        |-> result <= (($past(res_mode_i) == RES_8BIT)  ? 16'h00FF :
                       ($past(res_mode_i) == RES_10BIT) ? 16'h03FF :
                       ($past(res_mode_i) == RES_12BIT) ? 16'h0FFF :
                                                           16'hFFFF))
        else $error("result not saturated");
    a_trim_load: assert property (@(posedge clk_sys_i)
        disable iff (srst_i) trim_last |=> trim == $past(trim_found_i))
        else $error("trim words not loaded");
    a_single_stops: assert property (@(posedge clk_sys_i)
        disable iff (srst_i) set_end && !cont_conv && !trim_start
        |=> !conv_busy)
        else $error("single mode repeated");
    a_fail_verdict: assert property (@(posedge clk_sys_i)
        disable iff (srst_i) trim_last |=> trim_fail == $past(fail_now))
        else $error("wrong trim verdict");

endmodule : adc_selftrim_average_correction
`default_nettype wire

// *** rtl/adc_trim_consts.svh ***
// Register offsets, field positions, reset values and timing counts.
`ifndef ADC_TRIM_CONSTS_SVH
`define ADC_TRIM_CONSTS_SVH

// =====================================================================
// Register offsets
`define OFS_TRIM_AVG_CTRL  8'h24
`define OFS_OFFSET_CORR    8'h28
`define OFS_PLUS_GAIN      8'h2C
`define OFS_TRIM_D         8'h34
`define OFS_TRIM_S         8'h38
`define OFS_TRIM_FOUR      8'h3C
`define OFS_TRIM_THREE     8'h40
`define OFS_TRIM_TWO       8'h44
`define OFS_TRIM_ONE       8'h48
`define OFS_TRIM_ZERO      8'h4C
`define OFS_TRIG_CTRL      8'h50
`define OFS_RESULT         8'h54

// =====================================================================
// Field positions
`define BIT_TRIM_START     7
`define BIT_TRIM_FAIL      6
`define BIT_CONT           3
`define BIT_AVG_EN         2
`define BIT_HW_TRIG        0
`define BIT_SW_TRIG        1

// =====================================================================
// Reset values
`define RST_OFFSET_CORR    16'h0004
`define RST_PLUS_GAIN      16'h8200
`define RST_TRIM_D         6'h0A
`define RST_TRIM_S         6'h20
`define RST_TRIM_FOUR      10'h200
`define RST_TRIM_THREE     9'h100
`define RST_TRIM_TWO       8'h80
`define RST_TRIM_ONE       7'h40
`define RST_TRIM_ZERO      6'h20

// =====================================================================
// Timing
`define TRIM_CYCLES        16'd64
`define CONV_CYCLES        8'd8

`endif

// *** rtl/adc_trim_pkg.sv ***
// Types shared by the trim, averaging and correction block.
package adc_trim_pkg;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;

    typedef struct packed {
        logic [5:0] d;
        logic [5:0] s;
        logic [9:0] four;
        logic [8:0] three;
        logic [7:0] two;
        logic [6:0] one;
        logic [5:0] zero;
    } trim_words_t;

    typedef enum logic [1:0] {
        RES_8BIT,
        RES_10BIT,
        RES_12BIT,
        RES_16BIT
    } res_mode_t;

endpackage : adc_trim_pkg

// *** test/adc_selftrim_average_correction_test.sv ***
// Self-checking bench for the trim, averaging and correction block.
`timescale 1ns/1ps
`default_nettype none

module adc_selftrim_average_correction_test;
    import adc_trim_pkg::*;

    // =====================================================================
    // Stimulus and bookkeeping
    localparam int TL = 64;
    localparam int CL = 8;
    logic        clk_sys_i  = 1'b0;
    logic        srst_i     = 1'b1;
    reg_req_t    req        = '0;
    logic [31:0] rdata;
    logic [15:0] raw        = 16'h0000;
    logic        stop       = 1'b0;
    res_mode_t   res        = RES_16BIT;
    logic        conv_act;
    logic        done;
    logic        trimming;
    int          n_mismatch = 0;
    int          compares   = 0;
    int          n_done     = 0;
    int          cyc        = 0;
    int          c;
    int          d0;
    logic [31:0] d;
    trim_words_t found = '{6'h15, 6'h2A, 10'h3A5, 9'h1C3, 8'h5A, 7'h33, 6'h0F};
    logic [7:0]  regs [10] = '{8'h24, 8'h28, 8'h2C, 8'h34, 8'h38, 8'h3C,
                               8'h40, 8'h44, 8'h48, 8'h4C};
    logic [31:0] rstv [10] = '{32'h0, 32'h4, 32'h8200, 32'h0A, 32'h20,
                               32'h200, 32'h100, 32'h80, 32'h40, 32'h20};
    logic [31:0] mask [10] = '{32'h4F, 32'hFFFF, 32'hFFFF, 32'h3F, 32'h3F,
                               32'h3FF, 32'h1FF, 32'hFF, 32'h7F, 32'h3F};

    initial begin
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    adc_selftrim_average_correction #(
        .TRIM_LEN(TL),
        .CONV_LEN(CL)
    ) u_adc_selftrim_average_correction (
        .clk_sys_i    (clk_sys_i),
        .srst_i       (srst_i),
        .req_i        (req),
        .rdata_o      (rdata),
        .raw_sample_i (raw),
        .trim_found_i (found),
        .stop_mode_i  (stop),
        .res_mode_i   (res),
        .conv_active_o(conv_act),
        .result_done_o(done),
        .trimming_o   (trimming)
    );

    // A hang would otherwise leave the run without a verdict.
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (done === 1'b1) begin
            n_done <= n_done + 1;
        end
        if (cyc == 60000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // =====================================================================
    // Bus and compare tasks
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk_sys_i);
        req <= '{a, v, 1'b1, 1'b0};
        @(posedge clk_sys_i);
        req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk_sys_i);
        req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk_sys_i);
        req.rd <= 1'b0;
        #1;
        v = rdata;
    endtask : rd

    task automatic chk32(input string n, input logic [31:0] e,
                         input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk32

    task automatic chk1(input string n, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %b seen %b", n, e, g);
        end
    endtask : chk1

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        chk32($sformatf("register %h", a), e, v);
    endtask : rdchk

    // Reads are legal during trim; writes, hw_trig_sel and stop mode spoil it.
    task automatic trim_wait();
        c = 0;
        d = 32'h80;
        while (d[7] === 1'b1 && c < 200) begin
            rd(8'h24, d);
            c++;
        end
        chk1("trim ends", 1'b1, c < 200 && c > 10);
    endtask : trim_wait

    task automatic conv(input logic [31:0] ctl, input logic [15:0] r,
                        input logic [15:0] off, input logic [15:0] e,
                        input int n);
        wr(8'h28, {16'h0, off});
        wr(8'h24, ctl);
        raw <= r;
        d0 = n_done;
        wr(8'h50, 32'h2);
        c = 0;
        while (done !== 1'b1 && c < 1000) begin
            @(posedge clk_sys_i);
            #1;
            c++;
        end
        chk1("set length", 1'b1, c >= n * CL - 2 && c <= n * CL + 6);
        rdchk(8'h54, {16'h0, e});
        repeat (40) @(posedge clk_sys_i);
        chk32("single set", 32'd1, 32'(n_done - d0));
    endtask : conv

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : tally_and_finish

    // =====================================================================
    // Main sequence
    initial begin
        repeat (5) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            rdchk(regs[i], rstv[i]);
        end
        rdchk(8'h30, 32'h0);
        for (int i = 1; i < 10; i++) begin
            wr(regs[i], 32'hFFFF_FFFF);
            rdchk(regs[i], mask[i]);
        end
        wr(8'h24, 32'h3F);
        rdchk(8'h24, 32'h0F);
        conv(32'h0, 16'h1234, 16'h0004, 16'h1230, 1);
        conv(32'h0, 16'h0010, 16'h7FF0, 16'h0000, 1);
        conv(32'h0, 16'hFFF0, 16'h8000, 16'hFFFF, 1);
        res <= RES_8BIT;
        conv(32'h0, 16'h0300, 16'h0004, 16'h00FF, 1);
        res <= RES_10BIT;
        conv(32'h0, 16'h0123, 16'h0003, 16'h0120, 1);
        res <= RES_12BIT;
        conv(32'h0, 16'h1234, 16'h0000, 16'h0FFF, 1);
        res <= RES_16BIT;
        for (int a = 0; a < 4; a++) begin
            conv(32'h4 | a, 16'h2468, 16'h0, 16'h2468, 4 << a);
        end
        wr(8'h24, 32'h08);
        d0 = n_done;
        wr(8'h50, 32'h2);
        repeat (10 * CL) @(posedge clk_sys_i);
        #1;
        chk1("repeats", 1'b1, n_done - d0 >= 6);
        chk1("busy", 1'b1, conv_act);
        wr(8'h24, 32'h80);
        repeat (3) @(posedge clk_sys_i);
        #1;
        chk1("abort", 1'b0, conv_act);
        chk1("trimming", 1'b1, trimming);
        d0 = n_done;
        trim_wait();
        repeat (40) @(posedge clk_sys_i);
        chk32("after abort", 32'd0, 32'(n_done - d0));
        rdchk(8'h24, 32'h0);
        // trim words are only read back here; the trim loaded them from trim_found_i.
        rdchk(8'h34, 32'(found.d));
        rdchk(8'h38, 32'(found.s));
        rdchk(8'h3C, 32'(found.four));
        rdchk(8'h40, 32'(found.three));
        rdchk(8'h44, 32'(found.two));
        rdchk(8'h48, 32'(found.one));
        rdchk(8'h4C, 32'(found.zero));
        wr(8'h2C, 32'h0000_8100);
        rdchk(8'h2C, 32'h0000_8100);
        // Each pass spoils one trim in a different way.
        for (int k = 0; k < 3; k++) begin
            if (k == 2) begin
                wr(8'h50, 32'h1);
            end
            wr(8'h24, 32'h80);
            if (k == 0) begin
                wr(8'h28, 32'h0);
            end
            if (k == 1) begin
                stop <= 1'b1;
                repeat (4) @(posedge clk_sys_i);
                stop <= 1'b0;
            end
            trim_wait();
            if (k == 2) begin
                wr(8'h50, 32'h0);
            end
            rdchk(8'h24, 32'h40);
            wr(8'h24, 32'h0);
            rdchk(8'h24, 32'h40);
            wr(8'h24, 32'h40);
            rdchk(8'h24, 32'h0);
        end
        tally_and_finish();
    end

endmodule : adc_selftrim_average_correction_test

`default_nettype wire
